// ===== hdl/vic_defs.svh
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH

`define VIC_NUM_IRQ       30
`define VIC_ID_W          5
`define VIC_PRIO_W        3
`define VIC_SPLIT_W       2
`define VIC_PRIO_WORDS    4
`define VIC_PRIO_PER_WORD 8

`define VIC_OFF_ENABLE    12'h000
`define VIC_OFF_SETPEND   12'h004
`define VIC_OFF_CLRPEND   12'h008
`define VIC_OFF_ACTIVE    12'h00C
`define VIC_OFF_LEVELSEL  12'h010
`define VIC_OFF_SOFTTRIG  12'h014
`define VIC_OFF_PRIGROUP  12'h018
`define VIC_OFF_STATUS    12'h01C
`define VIC_OFF_MASK      12'h020
`define VIC_OFF_PRIO_BASE 12'h030

`define VIC_EV_NMI        0
`define VIC_EV_HWPEND     1
`define VIC_EV_LOSTPULSE  2
`define VIC_EV_W          3

`define VIC_RST_ENABLE    30'h00000000
`define VIC_RST_LEVELSEL  30'h3FFFFFFF
`define VIC_RST_PRIGROUP  2'h0
`define VIC_RST_MASK      3'h0

`define VIC_HTRANS_NONSEQ 2'h2

`endif

// ===== hdl/vic_pkg.sv
package vic_pkg;

  typedef logic [2:0] vic_prio_t;
  typedef logic [4:0] vic_id_t;

  // Request presented to the core
  typedef struct packed {
    logic      valid;
    logic      nmi;
    vic_id_t   id;
    vic_prio_t group;
    vic_prio_t sub;
  } vic_req_s;

  // Entry and return events from the core
  typedef struct packed {
    logic    enter;
    logic    leave;
    logic    nmi;
    vic_id_t id;
  } vic_evt_s;

endpackage

// ===== hdl/vic_arbiter.sv
`timescale 1ns/1ns
`default_nettype none

module vic_arbiter #(
  parameter int NUM = 30
) (
  // Candidates and their levels
  input  wire logic [NUM-1:0]   cand,
  input  wire logic [NUM*3-1:0] prioFlat,
  // Winner
  output logic                  found,
  output vic_pkg::vic_id_t      winId,
  output vic_pkg::vic_prio_t    winPrio
);
  import vic_pkg::*;

  // Strictly smaller wins, so ties stay with the lower number
  always_comb begin
    found   = 1'b0;
    winId   = 5'h00;
    winPrio = 3'h7;
    for (int i = 0; i < NUM; i++) begin
      if (cand[i] && (!found || prioFlat[i*3 +: 3] < winPrio)) begin //RULE2 RULE18
        found   = 1'b1;
        winId   = 5'(i);
        winPrio = prioFlat[i*3 +: 3];
      end
    end
  end

endmodule

`default_nettype wire

// ===== hdl/vic_state_ctrl.sv
// Functional notes
// RULE1: Each peripheral interrupt holds a programmable priority level 0 to 7.
// RULE2: Lower level number is more urgent; level 0 beats every other level.
// RULE3: Priority splits into group and subpriority fields for arbitration.
// RULE4: One non-maskable input exists besides the maskable peripheral lines.
// RULE5: Core stacks state on entry and restores it on return by itself.
// RULE6: Level source keeps its line high until serviced, then drops it.
// RULE7: Pulse lines are sampled on every rising clock edge.
// RULE8: Pulse source holds its line high for at least one clock.
// RULE9: Line high while interrupt is not active makes it pending.
// RULE10: A low-to-high transition on the line makes it pending.
// RULE11: Set-pending write or software trigger write makes it pending.
// RULE12: Entering the routine clears pending and marks the interrupt active.
// RULE13: Level return: line high repends it, otherwise it goes inactive.
// RULE14: Pulse during service gives active-and-pending; return leaves pending.
// RULE15: Pulse without new pulse during service returns to inactive.
// RULE16: Level clear-pending: no change if line high, otherwise inactive.
// RULE17: Pulse clear-pending: pending to inactive, active-and-pending to active.
// RULE18: Most urgent enabled pending wins; ties go to lowest number.
`timescale 1ns/1ns
`default_nettype none
`include "vic_defs.svh"

module vic_state_ctrl #(
  parameter int NUM = `VIC_NUM_IRQ
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              resetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Peripheral request lines
  input  wire logic [NUM-1:0]    irqLine,
  input  wire logic              nmiLine,
  // Core side
  input  wire vic_pkg::vic_evt_s coreEvt,
  output vic_pkg::vic_req_s      coreReq,
  // Interrupt to system
  output logic                   irqOut
);
  import vic_pkg::*;

  // One-hot of an interrupt number, zero when out of range
  function automatic logic [NUM-1:0] oneHot(input vic_id_t id);
    logic [NUM-1:0] v;
    v = '0;
    for (int i = 0; i < NUM; i++) begin
      if (5'(i) == id) begin
        v[i] = 1'b1;
      end
    end
    return v;
  endfunction

  // Group keeps the upper bits, sub the lower split bits
  function automatic vic_prio_t groupOf(input vic_prio_t p,
                                        input logic [1:0] s);
    return p >> s;
  endfunction

  function automatic vic_prio_t subOf(input vic_prio_t p,
                                      input logic [1:0] s);
    vic_prio_t m;
    m = vic_prio_t'((4'h1 << s) - 4'h1);
    return p & m;
  endfunction

  // Register state
  logic [NUM-1:0]   enable_q;
  logic [NUM-1:0]   levelSel_q;
  logic [1:0]       split_q;
  vic_prio_t        prio_q [NUM];
  logic [`VIC_EV_W-1:0] status_q;
  logic [`VIC_EV_W-1:0] mask_q;

  // Interrupt state
  logic [NUM-1:0]   pending_q;
  logic [NUM-1:0]   pending_d;
  logic [NUM-1:0]   active_q;
  logic [NUM-1:0]   active_d;
  logic [NUM-1:0]   lineSmp_q;
  logic [NUM-1:0]   linePrev_q;
  logic             nmiSmp_q;
  logic             nmiPrev_q;
  logic             nmiPend_q;

  // Bus state
  logic             wrPend_q;
  logic [11:0]      wrAddr_q;
  logic             hreadyout_q;
  logic [31:0]      hrdata_q;
  logic [31:0]      rdData;
  vic_req_s         coreReq_q;
  logic             irqOut_q;

  // Address phase
  logic             addrPhase;
  assign addrPhase = hsel && hready && (htrans == `VIC_HTRANS_NONSEQ ||
                                        htrans == 2'h3);

  // Write strobes during the first data cycle
  logic             wrNow;
  logic [NUM-1:0]   wrSetPend;
  logic [NUM-1:0]   wrClrPend;
  logic [NUM-1:0]   swTrigVec;
  assign wrNow     = wrPend_q && !hreadyout_q;
  assign wrSetPend = (wrNow && wrAddr_q == `VIC_OFF_SETPEND) ?
                     hwdata[NUM-1:0] : '0;
  assign wrClrPend = (wrNow && wrAddr_q == `VIC_OFF_CLRPEND) ?
                     hwdata[NUM-1:0] : '0;
  assign swTrigVec = (wrNow && wrAddr_q == `VIC_OFF_SOFTTRIG) ?
                     oneHot(hwdata[4:0]) : '0;

  // Writes take one wait state so a read right behind sees the new value
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wrPend_q    <= 1'b0;
      wrAddr_q    <= 12'h000;
      hreadyout_q <= 1'b1;
    end else begin
      if (addrPhase && hwrite) begin
        wrPend_q    <= 1'b1;
        wrAddr_q    <= {haddr[11:2], 2'h0};
        hreadyout_q <= 1'b0;
      end else if (wrNow) begin
        hreadyout_q <= 1'b1;
      end else begin
        wrPend_q    <= 1'b0;
      end
    end
  end

  // Read mux; unmapped reads as zero
  always_comb begin
    rdData = 32'h00000000;
    case (haddr[11:0] & 12'hFFC)
      `VIC_OFF_ENABLE:   rdData[NUM-1:0] = enable_q;
      `VIC_OFF_SETPEND,
      `VIC_OFF_CLRPEND:  rdData[NUM-1:0] = pending_q;
      `VIC_OFF_ACTIVE:   rdData[NUM-1:0] = active_q;
      `VIC_OFF_LEVELSEL: rdData[NUM-1:0] = levelSel_q;
      `VIC_OFF_PRIGROUP: rdData[1:0]     = split_q;
      `VIC_OFF_STATUS:   rdData[2:0]     = status_q;
      `VIC_OFF_MASK:     rdData[2:0]     = mask_q;
      default: begin
        if (haddr[11:4] == `VIC_OFF_PRIO_BASE >> 4) begin
          for (int j = 0; j < `VIC_PRIO_PER_WORD; j++) begin
            if (int'(haddr[3:2]) * `VIC_PRIO_PER_WORD + j < NUM) begin
              rdData[j*4 +: 3] =
                prio_q[int'(haddr[3:2]) * `VIC_PRIO_PER_WORD + j];
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      hrdata_q <= 32'h00000000;
    end else if (addrPhase && !hwrite) begin
      hrdata_q <= rdData;
    end
  end

  // Software-owned configuration
  always_ff @(posedge clock) begin
    if (!resetn) begin
      enable_q   <= `VIC_RST_ENABLE;
      levelSel_q <= `VIC_RST_LEVELSEL;
      split_q    <= `VIC_RST_PRIGROUP;
      mask_q     <= `VIC_RST_MASK;
    end else if (wrNow) begin
      case (wrAddr_q)
        `VIC_OFF_ENABLE:   enable_q   <= hwdata[NUM-1:0];
        `VIC_OFF_LEVELSEL: levelSel_q <= hwdata[NUM-1:0];
        `VIC_OFF_PRIGROUP: split_q    <= hwdata[1:0]; //RULE3
        `VIC_OFF_MASK:     mask_q     <= hwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // Priority levels, four bit lanes per interrupt, three used
  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < NUM; i++) begin
        prio_q[i] <= 3'h0;
      end
    end else if (wrNow && wrAddr_q[11:4] == `VIC_OFF_PRIO_BASE >> 4) begin
      for (int j = 0; j < `VIC_PRIO_PER_WORD; j++) begin
        if (int'(wrAddr_q[3:2]) * `VIC_PRIO_PER_WORD + j < NUM) begin
          prio_q[int'(wrAddr_q[3:2]) * `VIC_PRIO_PER_WORD + j] <=
            hwdata[j*4 +: 3]; //RULE1
        end
      end
    end
  end

  // Request sampling; sources share this clock
  always_ff @(posedge clock) begin
    if (!resetn) begin
      lineSmp_q  <= '0;
      linePrev_q <= '0;
      nmiSmp_q   <= 1'b0;
      nmiPrev_q  <= 1'b0;
    end else begin
      lineSmp_q  <= irqLine; //RULE7 RULE8
      linePrev_q <= lineSmp_q;
      nmiSmp_q   <= nmiLine;
      nmiPrev_q  <= nmiSmp_q;
    end
  end

  // Core stacks and unstacks itself; only entry and return are seen here
  logic [NUM-1:0] enterVec;
  logic [NUM-1:0] leaveVec;
  assign enterVec = (coreEvt.enter && !coreEvt.nmi) ?
                    oneHot(coreEvt.id) : '0; //RULE5
  assign leaveVec = (coreEvt.leave && !coreEvt.nmi) ?
                    oneHot(coreEvt.id) : '0;

  logic [NUM-1:0] levelHigh;
  logic [NUM-1:0] levelSet;
  logic [NUM-1:0] edgeSet;
  logic [NUM-1:0] clrVec;
  logic [NUM-1:0] reArm;
  logic [NUM-1:0] lostPulse;

  // Level source holds its line until serviced
  assign levelHigh = levelSel_q & lineSmp_q; //RULE6
  assign levelSet  = levelHigh & ~active_q & ~enterVec; //RULE9
  assign edgeSet   = lineSmp_q & ~linePrev_q; //RULE10
  assign clrVec    = wrClrPend & ~levelHigh; //RULE16 RULE17
  assign reArm     = leaveVec & levelHigh; //RULE13
  assign lostPulse = edgeSet & pending_q & ~levelSel_q;

  // Sets win over entry and clear in the same cycle, except the level set, which entry blocks
  always_comb begin
    pending_d = (pending_q & ~enterVec & ~clrVec) //RULE12
              | levelSet | edgeSet | reArm //RULE14
              | wrSetPend | swTrigVec; //RULE11
    active_d  = (active_q | enterVec) & ~leaveVec; //RULE12 RULE15
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pending_q <= '0;
      active_q  <= '0;
    end else begin
      pending_q <= pending_d;
      active_q  <= active_d;
    end
  end

  // Non-maskable input, latched on its rising edge
  always_ff @(posedge clock) begin
    if (!resetn) begin
      nmiPend_q <= 1'b0;
    end else if (nmiSmp_q && !nmiPrev_q) begin
      nmiPend_q <= 1'b1; //RULE4
    end else if (coreEvt.enter && coreEvt.nmi) begin
      nmiPend_q <= 1'b0;
    end
  end

  // Arbitration over enabled pending lines
  logic             found;
  vic_id_t          winId;
  vic_prio_t        winPrio;
  logic [NUM*3-1:0] prioFlat;

  always_comb begin
    for (int i = 0; i < NUM; i++) begin
      prioFlat[i*3 +: 3] = prio_q[i];
    end
  end

  vic_arbiter #(
    .NUM      (NUM)
  ) uArb (
    .cand     (pending_q & enable_q),
    .prioFlat (prioFlat),
    .found    (found),
    .winId    (winId),
    .winPrio  (winPrio)
  );

  // NMI outranks every maskable request
  always_ff @(posedge clock) begin
    if (!resetn) begin
      coreReq_q <= '0;
    end else begin
      coreReq_q.valid <= nmiPend_q || found; //RULE18
      coreReq_q.nmi   <= nmiPend_q; //RULE4
      coreReq_q.id    <= nmiPend_q ? 5'h00 : winId;
      coreReq_q.group <= nmiPend_q ? 3'h0 : groupOf(winPrio, split_q); //RULE3
      coreReq_q.sub   <= nmiPend_q ? 3'h0 : subOf(winPrio, split_q);
    end
  end

  // Sticky event flags, write one to clear, set wins
  logic [`VIC_EV_W-1:0] evSet;
  logic [`VIC_EV_W-1:0] evClr;
  assign evSet[`VIC_EV_NMI]       = nmiSmp_q && !nmiPrev_q;
  assign evSet[`VIC_EV_HWPEND]    = |((levelSet | edgeSet) & ~pending_q);
  assign evSet[`VIC_EV_LOSTPULSE] = |lostPulse;
  assign evClr = (wrNow && wrAddr_q == `VIC_OFF_STATUS) ?
                 hwdata[2:0] : '0;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      status_q <= '0;
      irqOut_q <= 1'b0;
    end else begin
      status_q <= (status_q & ~evClr) | evSet;
      irqOut_q <= |(status_q & mask_q);
    end
  end

  // Always OKAY; still a flop so every output leaves a register
  logic             hresp_q;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign hrdata    = hrdata_q;
  assign coreReq   = coreReq_q;
  assign irqOut    = irqOut_q;

endmodule

`default_nettype wire

// ===== test/vic_state_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none

module vic_state_ctrl_assertions #(
  parameter int NUM = 30
) (
  // Clock and reset
  input wire logic              clock,
  input wire logic              resetn,
  // Bus
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata,
  // Lines and core
  input wire logic [NUM-1:0]    irqLine,
  input wire logic              nmiLine,
  input wire vic_pkg::vic_evt_s coreEvt,
  input wire vic_pkg::vic_req_s coreReq,
  input wire logic              irqOut
);
  import vic_pkg::*;
  logic taken;
  assign taken = hsel && hready && htrans[1];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  reset_values_a: assert property ($rose(resetn) |-> hreadyout && !irqOut
    && hrdata == 32'h0 && coreReq == 13'h0) else $error("bad reset value");
  okay_resp_a: assert property (hresp == 1'b0) else $error("hresp not OKAY");
  write_wait_a: assert property (taken && hwrite |=> !hreadyout ##1 hreadyout)
    else $error("write wait wrong");
  read_nowait_a: assert property (taken && !hwrite |=> hreadyout)
    else $error("read wait wrong");
  rdata_hold_a: assert property (!(taken && !hwrite) |=> $stable(hrdata))
    else $error("hrdata moved");
  nmi_fields_a: assert property (coreReq.nmi |-> coreReq.valid &&
    coreReq.id == 5'h00 && coreReq.group == 3'h0 && coreReq.sub == 3'h0)
    else $error("nmi request fields");
  nmi_pend_a: assert property ($rose(nmiLine) |-> ##3 coreReq.nmi)
    else $error("nmi not presented");
  nmi_entry_clr_a: assert property (!$rose(nmiLine) ##1
    (coreEvt.enter && coreEvt.nmi) |-> ##2 !coreReq.nmi)
    else $error("nmi entry kept pending");
endmodule

bind vic_state_ctrl vic_state_ctrl_assertions #(.NUM(NUM)) u_chk (
  .clock, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
  .hready, .hreadyout, .hresp, .hrdata, .irqLine, .nmiLine, .coreEvt,
  .coreReq, .irqOut);

`default_nettype wire

// ===== test/vic_core_model.sv
`timescale 1ns/1ns
`default_nettype none

module vic_core_model (
  // Clock and reset
  input wire logic              clock,
  input wire logic              resetn,
  // Presented request
  input wire vic_pkg::vic_req_s coreReq,
  // Bench commands
  input wire logic              doEnter,
  input wire logic              doLeave,
  // Events to controller
  output vic_pkg::vic_evt_s     coreEvt
);
  import vic_pkg::*;
  // One nesting level only; enough for these sequences
  vic_evt_s heldEvt_q;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      coreEvt <= 8'h00;
      heldEvt_q <= 8'h00;
    end else if (doEnter) begin
      coreEvt <= {2'h2, coreReq.nmi, coreReq.id};
      heldEvt_q <= {2'h0, coreReq.nmi, coreReq.id};
    end else if (doLeave) begin
      coreEvt <= heldEvt_q | 8'h40;
    end else begin
      coreEvt <= 8'h00;
    end
  end
endmodule

`default_nettype wire

// ===== test/vic_state_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "vic_defs.svh"

module vic_state_ctrl_tb;
  import vic_pkg::*;
  logic        clock, resetn, hsel, hwrite, hreadyout, hresp, irqOut;
  logic        nmiLine, doEnter, doLeave;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [29:0] irqLine;
  vic_evt_s    coreEvt;
  vic_req_s    coreReq;
  int          nErrors, checks;

  vic_state_ctrl #(.NUM(30)) u_dut (.clock, .resetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .irqLine, .nmiLine, .coreEvt, .coreReq,
    .irqOut);
  vic_core_model u_core (.clock, .resetn, .coreReq, .doEnter, .doLeave,
    .coreEvt);

  always #10 clock = ~clock;

  task automatic testDone();
    $display("checks=%0d errors=%0d", checks, nErrors);
    if (nErrors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      nErrors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Entered just after a rising edge; waits on hready, no fixed latency
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= `VIC_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {20'h00000, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h00000000, x);
    chk(x, e);
  endtask
  task automatic core(input logic en);
    if (en) doEnter <= 1'b1;
    else doLeave <= 1'b1;
    tick(1);
    doEnter <= 1'b0;
    doLeave <= 1'b0;
    tick(3);
  endtask
  task automatic pulse1();
    irqLine[1] <= 1'b1;
    tick(1);
    irqLine[1] <= 1'b0;
    tick(3);
  endtask

  initial begin
    #200000;
    nErrors++;
    testDone();
  end

  initial begin
    clock = 0; resetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hwdata = 0; irqLine = 0; nmiLine = 0; doEnter = 0; doLeave = 0;
    tick(2);
    resetn <= 1'b1;
    tick(1);
    rc(`VIC_OFF_ENABLE, 32'h00000000);
    rc(`VIC_OFF_LEVELSEL, 32'h3FFFFFFF);
    rc(12'h024, 32'h00000000);
    // Levels: irq1 and irq3 at 5, irq7 at 2
    wr(`VIC_OFF_PRIO_BASE, 32'h20005050);
    rc(`VIC_OFF_PRIO_BASE, 32'h20005050);
    wr(`VIC_OFF_ENABLE, 32'h0000008A);
    wr(`VIC_OFF_LEVELSEL, 32'h3FFFFFFD);
    wr(`VIC_OFF_SETPEND, 32'h0000000A);
    tick(2);
    chk(32'(coreReq.id), 32'h1);
    chk(32'(coreReq.valid), 32'h1);
    wr(`VIC_OFF_SOFTTRIG, 32'h00000007);
    tick(2);
    chk(32'(coreReq.id), 32'h7);
    chk(32'(coreReq.group), 32'h2);
    chk(32'(coreReq.sub), 32'h0);
    // Two sub bits: level 2 splits into group 0, sub 2
    wr(`VIC_OFF_PRIGROUP, 32'h00000002);
    tick(2);
    chk(32'(coreReq.group), 32'h0);
    chk(32'(coreReq.sub), 32'h2);
    core(1'b1);
    rc(`VIC_OFF_ACTIVE, 32'h00000080);
    rc(`VIC_OFF_SETPEND, 32'h0000000A);
    core(1'b0);
    rc(`VIC_OFF_ACTIVE, 32'h00000000);
    wr(`VIC_OFF_CLRPEND, 32'h0000000A);
    rc(`VIC_OFF_SETPEND, 32'h00000000);
    irqLine[3] <= 1'b1;
    tick(3);
    rc(`VIC_OFF_SETPEND, 32'h00000008);
    wr(`VIC_OFF_CLRPEND, 32'h00000008);
    rc(`VIC_OFF_SETPEND, 32'h00000008);
    core(1'b1);
    rc(`VIC_OFF_SETPEND, 32'h00000000);
    core(1'b0);
    rc(`VIC_OFF_SETPEND, 32'h00000008);
    irqLine[3] <= 1'b0;
    wr(`VIC_OFF_CLRPEND, 32'h00000008);
    rc(`VIC_OFF_SETPEND, 32'h00000000);
    pulse1();
    rc(`VIC_OFF_SETPEND, 32'h00000002);
    core(1'b1);
    pulse1();
    rc(`VIC_OFF_SETPEND, 32'h00000002);
    wr(`VIC_OFF_CLRPEND, 32'h00000002);
    rc(`VIC_OFF_SETPEND, 32'h00000000);
    rc(`VIC_OFF_ACTIVE, 32'h00000002);
    pulse1();
    core(1'b0);
    rc(`VIC_OFF_SETPEND, 32'h00000002);
    core(1'b1);
    core(1'b0);
    rc(`VIC_OFF_SETPEND, 32'h00000000);
    rc(`VIC_OFF_ACTIVE, 32'h00000000);
    chk(32'(coreReq.valid), 32'h0);
    // Line events left status bit 1 set; mask still holds it off
    chk(32'(irqOut), 32'h0);
    wr(`VIC_OFF_MASK, 32'h00000002);
    tick(2);
    chk(32'(irqOut), 32'h1);
    wr(`VIC_OFF_STATUS, 32'h00000002);
    tick(2);
    chk(32'(irqOut), 32'h0);
    // Second pulse while still pending is flagged as lost
    pulse1();
    pulse1();
    rc(`VIC_OFF_STATUS, 32'h00000006);
    wr(`VIC_OFF_CLRPEND, 32'h00000002);
    rc(`VIC_OFF_SETPEND, 32'h00000000);
    wr(`VIC_OFF_STATUS, 32'h00000006);
    rc(`VIC_OFF_STATUS, 32'h00000000);
    wr(`VIC_OFF_MASK, 32'h00000001);
    nmiLine <= 1'b1;
    tick(4);
    chk(32'(coreReq.nmi), 32'h1);
    chk(32'(irqOut), 32'h1);
    core(1'b1);
    chk(32'(coreReq.nmi), 32'h0);
    nmiLine <= 1'b0;
    core(1'b0);
    testDone();
  end
endmodule

`default_nettype wire
